// >>> src/kspr_regs.svh
// Register offsets, field positions, reset values and counts of the key-scan config bank.
// Assumes byte-wide registers at the printed offsets of the host register port.
`ifndef KSPR_REGS_SVH
`define KSPR_REGS_SVH

`define KSPR_ADDR_DEBOUNCE      8'h02
`define KSPR_ADDR_PORT_LEVELS   8'h04
`define KSPR_ADDR_REPEAT        8'h05
`define KSPR_ADDR_SLEEP         8'h06

`define KSPR_RST_DEBOUNCE       8'hFF
`define KSPR_RST_PORT_LEVELS    8'hFE
`define KSPR_RST_REPEAT         8'h00
`define KSPR_RST_SLEEP          8'h07
`define KSPR_RST_PORT_EN        6'h3F

`define KSPR_PORT_LEVELS_MASK   8'hFE
`define KSPR_SLEEP_MASK         8'h07
`define KSPR_IRQ_PIN_BIT        1
`define KSPR_REP_EN_BIT         7
`define KSPR_DELAY_STEP         8'h08
`define KSPR_RATE_STEP          8'h04
`define KSPR_SLEEP_MAX_MS       14'h2000
`define KSPR_SLEEP_MIN_MS       14'h0100

`endif

// >>> src/kspr_pkg.sv
// Types shared by the key-scan configuration bank.
// Assumes the constants header is included by the modules that need it.
package kspr_pkg;

    typedef enum logic [1:0] {
        KSPR_REP_IDLE,
        KSPR_REP_DELAY,
        KSPR_REP_RUN
    } kspr_rep_state_t;

    typedef struct packed {
        logic [7:0]      debounce;
        logic [7:0]      port_levels;
        logic [7:0]      repeat_cfg;
        logic [7:0]      sleep_cfg;
        logic [7:0]      rdata;
        logic [7:2]      port_en;
        logic [7:2]      port_oe;
        logic            irq_oe;
        kspr_rep_state_t rep_state;
        logic            repeat_event;
        logic            sleep;
    } kspr_state_t;

endpackage

// >>> src/kspr_tick_counter.sv
// Counts tick pulses and pulses its hit output when the programmed limit is reached.
// Assumes i_limit is at least one and stable while counting; a clear restarts from zero.
`timescale 1ns/1ps

module kspr_tick_counter #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_clear,
    input  wire logic         i_tick,
    input  wire logic [W-1:0] i_limit,
    output logic              o_hit
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         hit;
    } kspr_cnt_state_t;

    kspr_cnt_state_t st_q;
    kspr_cnt_state_t st_d;

    always_comb begin
        st_d     = st_q;
        st_d.hit = 1'b0;
        if (i_clear) begin
            st_d.cnt = '0;
        end else if (i_tick) begin
            if (st_q.cnt + W'(1) >= i_limit) begin
                st_d.cnt = '0;
                st_d.hit = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_hit = st_q.hit;

endmodule

// >>> src/kspr_config_bank.sv
// Key-scan configuration bank: port output levels, autorepeat timing and autosleep timeout.
// Assumes a byte register port driven by the serial-interface front end, a one-cycle pulse
// per debounce cycle and per millisecond, and the key scanner reporting held keys and activity.
//
// Notes on behaviour
// - Port bits 7..2 low pull column ports enabled as outputs low; high releases them; reset one.
// - Port bit 1 drives the interrupt pin low when used as output; resets one.
// - Repeat only when bit 7 set; first repeat after (delay+1)*8 debounce cycles.
// - Repeat interval is (rate+1)*4 debounce cycles while repeat is enabled.
// - Debounce bits 7:5 give output-port count, counted downward from port 7.
`timescale 1ns/1ps
`include "kspr_regs.svh"

module kspr_config_bank
    import kspr_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_wr_en,
    input  wire logic       i_rd_en,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata,
    input  wire logic       i_debounce_tick,
    input  wire logic       i_ms_tick,
    input  wire logic       i_key_held,
    input  wire logic       i_key_activity,
    input  wire logic       i_irq_pin_gpo_mode,
    input  wire logic       i_irq_pin_assert,
    output logic      [4:0] o_debounce_time,
    output logic      [7:2] o_general_output_port_en,
    output logic      [7:2] o_general_output_port_out,
    output logic      [7:2] o_general_output_port_oe,
    output logic            o_key_event_irq_pin_out,
    output logic            o_key_event_irq_pin_oe,
    output logic            o_repeat_event,
    output logic            o_sleep
);

    // All register state except the timer counts and the pin-level flops lives in one packed struct. The next value is built in a single
    // combinational process and registered in a single clocked process, so every output
    // of this module comes straight from a flip-flop.
    kspr_state_t st_q;
    kspr_state_t st_d;

    // Hit pulses of the two tick counters, one cycle after the completing tick.
    logic        rep_hit;
    logic        sleep_hit;
    logic        rep_clear;
    logic        sleep_clear;
    logic [7:0]  rep_limit;
    logic [13:0] sleep_limit;

    // Column p is a general output when the enabled count reaches 8 - p.
    function automatic logic gpo_enabled(input logic [2:0] code, input int p);
        logic [2:0] count;
        count = (code[2] && code[1]) ? 3'h6 : code;
        return (int'(count) >= (8 - p));
    endfunction

    // Codes above five saturate at the shortest timeout.
    function automatic logic [13:0] sleep_ms(input logic [2:0] code);
        logic [2:0] c;
        c = (code > 3'h5) ? 3'h6 : code;
        return (c == 3'h0) ? 14'h0000 : (`KSPR_SLEEP_MAX_MS >> (c - 3'h1));
    endfunction

    always_comb begin
        st_d              = st_q;
        st_d.repeat_event = 1'b0;

        // Writes to unmapped offsets are dropped without any side effect.
        // Reserved bits are masked on the way in so that they always read back as zero.
        if (i_wr_en) begin
            case (i_addr)
                `KSPR_ADDR_DEBOUNCE:    st_d.debounce    = i_wdata;
                `KSPR_ADDR_PORT_LEVELS: st_d.port_levels = i_wdata & `KSPR_PORT_LEVELS_MASK;
                `KSPR_ADDR_REPEAT:      st_d.repeat_cfg  = i_wdata;
                `KSPR_ADDR_SLEEP:       st_d.sleep_cfg   = i_wdata & `KSPR_SLEEP_MASK;
                default: ;
            endcase
        end

        // Reads return the value held before any write in the same cycle.
        if (i_rd_en) begin
            case (i_addr)
                `KSPR_ADDR_DEBOUNCE:    st_d.rdata = st_q.debounce;
                `KSPR_ADDR_PORT_LEVELS: st_d.rdata = st_q.port_levels;
                `KSPR_ADDR_REPEAT:      st_d.rdata = st_q.repeat_cfg;
                `KSPR_ADDR_SLEEP:       st_d.rdata = st_q.sleep_cfg;
                default:                st_d.rdata = 8'h00;
            endcase
        end

        // The enables and drives are worked out from the next register values, so the pins
        // move on the same edge as the register that controls them.
        // A column that is still scanned keys is never pulled low from here, whatever its
        // level bit holds; that keeps a stale level bit from fighting the key scanner.
        for (int p = 2; p <= 7; p++) begin
            st_d.port_en[p] = gpo_enabled(st_d.debounce[7:5], p);
            st_d.port_oe[p] = gpo_enabled(st_d.debounce[7:5], p)
                              && !st_d.port_levels[p];
        end

        // Outside output mode the interrupt logic owns the pin.
        st_d.irq_oe = i_irq_pin_gpo_mode ? !st_d.port_levels[`KSPR_IRQ_PIN_BIT]
                                         : i_irq_pin_assert;

        // Autorepeat walks idle, initial delay, then steady repeat. Releasing the key or
        // clearing the enable bit drops back to idle and restarts the timer, so a new press
        // always waits the full initial delay again.
        // The tick that arrives in the cycle of entry is lost; the delay is therefore at
        // most one debounce cycle longer than programmed, never shorter.
        case (st_q.rep_state)
            KSPR_REP_IDLE: begin
                if (rep_clear == 1'b0) begin
                    st_d.rep_state = KSPR_REP_DELAY;
                end
            end
            KSPR_REP_DELAY, KSPR_REP_RUN: begin
                if (rep_clear) begin
                    st_d.rep_state = KSPR_REP_IDLE;
                end else if (rep_hit) begin
                    st_d.repeat_event = 1'b1;
                    st_d.rep_state    = KSPR_REP_RUN;
                end
            end
            default: st_d.rep_state = KSPR_REP_IDLE;
        endcase

        // Activity wins over a timeout that completes in the same cycle: a key that is
        // being touched must never be put to sleep.
        if (i_key_activity || sleep_ms(st_q.sleep_cfg[2:0]) == 14'h0000) begin
            st_d.sleep = 1'b0;
        end else if (sleep_hit) begin
            st_d.sleep = 1'b1;
        end
    end

    always_comb begin
        rep_clear = !(i_key_held && st_q.repeat_cfg[`KSPR_REP_EN_BIT]);
        if (st_q.rep_state == KSPR_REP_RUN) begin
            rep_limit = (8'(st_q.repeat_cfg[6:4]) + 8'h01) * `KSPR_RATE_STEP;
        end else begin
            rep_limit = (8'(st_q.repeat_cfg[3:0]) + 8'h01) * `KSPR_DELAY_STEP;
        end
        // The sleep timer is held in clear while asleep, while disabled and whenever the
        // timeout register is written, so a new code always starts a fresh count.
        sleep_limit = sleep_ms(st_q.sleep_cfg[2:0]);
        sleep_clear = i_key_activity || st_q.sleep || (sleep_limit == 14'h0000)
                      || (i_wr_en && i_addr == `KSPR_ADDR_SLEEP);
    end

    // The repeat timer counts debounce ticks up to at most 128, so eight bits suffice.
    kspr_tick_counter #(.W(8)) u_repeat_timer (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_clear (rep_clear || st_q.rep_state == KSPR_REP_IDLE),
        .i_tick  (i_debounce_tick),
        .i_limit (rep_limit),
        .o_hit   (rep_hit)
    );

    // The sleep timer counts millisecond ticks up to 8192, which needs fourteen bits.
    kspr_tick_counter #(.W(14)) u_sleep_timer (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_clear (sleep_clear),
        .i_tick  (i_ms_tick),
        .i_limit (sleep_limit),
        .o_hit   (sleep_hit)
    );

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q             <= '0;
            st_q.debounce    <= `KSPR_RST_DEBOUNCE;
            st_q.port_levels <= `KSPR_RST_PORT_LEVELS;
            st_q.repeat_cfg  <= `KSPR_RST_REPEAT;
            st_q.sleep_cfg   <= `KSPR_RST_SLEEP;
            st_q.port_en     <= `KSPR_RST_PORT_EN;
            st_q.rep_state   <= KSPR_REP_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Open-drain: the level is always low, only the enable moves.
    always_ff @(posedge i_clk) begin
        o_general_output_port_out <= 6'h00;
        o_key_event_irq_pin_out   <= 1'b0;
    end

    assign o_rdata                  = st_q.rdata;
    assign o_debounce_time          = st_q.debounce[4:0];
    assign o_general_output_port_oe = st_q.port_oe;
    assign o_key_event_irq_pin_oe   = st_q.irq_oe;
    assign o_repeat_event           = st_q.repeat_event;
    assign o_sleep                  = st_q.sleep;

    // The enable map is registered like every other output, so the pin multiplexers
    // outside see no decode glitches when the debounce register is rewritten.
    assign o_general_output_port_en = st_q.port_en;

endmodule

// >>> bench/kspr_config_bank_properties.sv
// Port-level assertions for the key-scan configuration bank.
// Assumes it is bound to kspr_config_bank; one clock, synchronous reset.
`timescale 1ns/1ps

module kspr_config_bank_properties (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_wr_en,
    input wire logic       i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic       i_ms_tick,
    input wire logic       i_key_held,
    input wire logic       i_key_activity,
    input wire logic       i_irq_pin_gpo_mode,
    input wire logic [7:2] o_general_output_port_en,
    input wire logic [7:2] o_general_output_port_out,
    input wire logic [7:2] o_general_output_port_oe,
    input wire logic       o_key_event_irq_pin_out,
    input wire logic       o_key_event_irq_pin_oe,
    input wire logic       o_repeat_event,
    input wire logic       o_sleep
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_wr(a);
        i_wr_en && i_addr == a;
    endsequence

    a_port_oe_map: assert property (s_wr(8'h04) |=> o_general_output_port_oe ==
        (~$past(i_wdata[7:2]) & o_general_output_port_en)) else $error("port drive wrong");
    a_gpo_decode: assert property (s_wr(8'h02) |=>
        o_general_output_port_en == ~(6'h3F >> $past(i_wdata[7:5]))) else $error("enable wrong");
    a_irq_pin_gpo: assert property (s_wr(8'h04) ##0 i_irq_pin_gpo_mode |=>
        o_key_event_irq_pin_oe == !$past(i_wdata[1])) else $error("irq pin drive wrong");
    a_pin_out_low: assert property (o_general_output_port_out == 6'h00
        && !o_key_event_irq_pin_out) else $error("pin level not low");
    a_unmapped_rd: assert property (i_rd_en && !(i_addr inside {8'h02, 8'h04, 8'h05, 8'h06})
        |=> o_rdata == 8'h00) else $error("unmapped read not zero");
    a_repeat_quiet: assert property ((!i_key_held)[*3] |-> !o_repeat_event)
        else $error("repeat without held key");
    a_sleep_wake: assert property (i_key_activity |-> ##[1:2] !o_sleep)
        else $error("activity did not wake");
    a_sleep_tick: assert property ($rose(o_sleep) |-> $past(i_ms_tick, 2))
        else $error("sleep not after tick");
endmodule

bind kspr_config_bank kspr_config_bank_properties i_props (.*);

// >>> bench/kspr_host_model.sv
// Host side of the register port: single byte writes and reads.
// Assumes one request at a time from the bench's main process.
`timescale 1ns/1ps

module kspr_host_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    output logic            o_wr_en,
    output logic            o_rd_en,
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata
);
    initial {o_wr_en, o_rd_en, o_addr, o_wdata} = 18'h0;

    // Idle address and data are inverted so a stale value never looks like a request.
    task automatic req(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        {o_wr_en, o_rd_en, o_addr, o_wdata} = {w, !w, a, d};
        @(negedge i_clk);
        {o_wr_en, o_rd_en, o_addr, o_wdata} = {2'b00, ~a, ~d};
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        req(1'b0, a, 8'h00);
        @(negedge i_clk);
        d = i_rdata;
    endtask
endmodule

// >>> bench/tb.sv
// Self-checking bench for the key-scan configuration bank.
// Assumes the host model drives the register port; ticks and key inputs come from here.
`timescale 1ns/1ps

module tb;
    logic i_clk = 0, i_rst = 1, i_wr_en, i_rd_en, i_debounce_tick = 0, i_ms_tick = 0;
    logic i_key_held = 0, i_key_activity = 0, i_irq_pin_gpo_mode = 1, i_irq_pin_assert = 0;
    logic [7:0] i_addr, i_wdata, o_rdata, v;
    logic [4:0] o_debounce_time;
    logic [7:2] o_general_output_port_en, o_general_output_port_out, o_general_output_port_oe;
    logic o_key_event_irq_pin_out, o_key_event_irq_pin_oe, o_repeat_event, o_sleep;
    int n_errors = 0, cmp_count = 0, ev, n;

    initial forever #2.5 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_repeat_event) ev++;

    kspr_host_model i_kspr_host_model (.i_clk(i_clk), .i_rdata(o_rdata), .o_wr_en(i_wr_en),
        .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wdata(i_wdata));
    kspr_config_bank i_kspr_config_bank (.*);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        i_kspr_host_model.rd(a, v);
        chk(v, e);
    endtask

    // Four cycles per tick leave room for the two-cycle answer before the next tick.
    task automatic pump(input bit ms, input int lim, output int k);
        k = 0;
        while (k < lim && !(ms ? o_sleep === 1'b1 : ev > 0)) begin
            @(negedge i_clk);
            {i_ms_tick, i_debounce_tick} = {ms, !ms};
            k++;
            @(negedge i_clk);
            {i_ms_tick, i_debounce_tick} = 2'b00;
            repeat (2) @(negedge i_clk);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        void'($urandom(2));
        repeat (4) @(negedge i_clk);
        i_rst = 0;
        rdchk(8'h02, 8'hFF);
        rdchk(8'h04, 8'hFE);
        rdchk(8'h05, 8'h00);
        rdchk(8'h06, 8'h07);
        chk(o_general_output_port_en, 6'h3F);
        i_kspr_host_model.rd(8'h33, v);
        chk(o_general_output_port_oe, 6'h00);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            v = {3'(i), 5'($urandom)};
            i_kspr_host_model.wr(8'h02, v);
            chk(o_general_output_port_en, 6'(~(6'h3F >> i)));
            chk(o_debounce_time, v[4:0]);
        end
        repeat (6) begin
            v = 8'($urandom);
            i_kspr_host_model.wr(8'h04, v);
            chk(o_general_output_port_oe, 6'(~v[7:2]));
            chk(o_key_event_irq_pin_oe, !v[1]);
            rdchk(8'h04, v & 8'hFE);
        end
        $display("test ports done");
        for (int k = 0; k < 4; k++) begin
            v = (k == 2) ? 8'($urandom) | 8'h80 : (k == 3 ? 8'h7F : {k[0], 7'h7F * k[0]} | 8'h80);
            i_kspr_host_model.wr(8'h05, v);
            i_key_held = 1;
            repeat (2) @(negedge i_clk);
            ev = 0;
            pump(0, 140, n);
            chk(n, v[7] ? (v[3:0] + 1) * 8 : 140);
            ev = 0;
            pump(0, 40, n);
            chk(n, v[7] ? (v[6:4] + 1) * 4 : 40);
            i_key_held = 0;
            @(negedge i_clk);
        end
        $display("test repeat done");
        for (int c = 0; c < 8; c++) begin
            i_kspr_host_model.wr(8'h06, 8'(c) | 8'hF8);
            rdchk(8'h06, 8'(c));
            pump(1, c == 0 ? 300 : 8200, n);
            chk(n, c == 0 ? 300 : (c > 5 ? 256 : 16384 >> c));
            i_key_activity = 1;
            @(negedge i_clk);
            i_key_activity = 0;
            repeat (2) @(negedge i_clk);
            chk(o_sleep, 1'b0);
        end
        $display("test sleep done");
        i_irq_pin_gpo_mode = 0;
        i_irq_pin_assert = 1;
        repeat (3) @(negedge i_clk);
        chk(o_key_event_irq_pin_oe, 1'b1);
        i_irq_pin_assert = 0;
        repeat (2) @(negedge i_clk);
        chk(o_key_event_irq_pin_oe, 1'b0);
        $display("test irq pin done");
        give_verdict();
    end
endmodule
